/* File: logic/mbs_sequencer.sv */
// Sequencing, protection and gate-state logic of a multiphase buck.
// Assumes analog comparators and an ADC outside supply levels; the core
// undervoltage comparator acts as the asynchronous reset.
`timescale 1ns/10ps

module mbs_sequencer #(
	parameter int unsigned P_FOUR_PHASE = 1,
	parameter int unsigned P_EN_DELAY_CYC = mbs_pkg::EN_DELAY_CYC
)
(
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_enable,
	input wire logic i_driver_supply_ok,
	input wire logic i_third_phase_tied,
	input wire logic i_fourth_phase_tied,
	input wire logic [1:0] i_arch_sel,
	input wire logic [7:0] i_voltage_code_ref,
	input wire logic [7:0] i_prog_current,
	input wire logic i_out_above_margin,
	input wire logic i_out_above_abs,
	input wire logic i_thermal_hot,
	input wire logic i_thermal_cool,
	input wire logic i_temp_over_trip,
	input wire logic i_in_regulation,
	input wire logic [3:0] i_phase_pwm,
	input wire logic [1:0] i_switch_node_low,
	input wire logic [1:0] i_low_gate_below,
	output logic [3:0] o_phase_drive,
	output logic [1:0] o_phase_count_m2,
	output logic [1:0] o_high_side_gate,
	output logic [1:0] o_low_side_gate,
	output logic [8:0] o_reference_target,
	output logic o_softstart_drive_2v,
	output logic o_softstart_pull_vcc,
	output logic o_power_good_out,
	output logic o_overtemp_flag_oe
);

	////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'h1};
	end
	assign rst_n = rst_sync_q[1];

	localparam int unsigned SW = 16;
	logic [SW-1:0] raw_in;
	logic [SW-1:0] s1_q;
	logic [SW-1:0] s2_q;
	assign raw_in = {i_enable, i_driver_supply_ok, i_out_above_margin,
		i_out_above_abs, i_thermal_hot, i_thermal_cool, i_temp_over_trip,
		i_in_regulation, i_switch_node_low, i_low_gate_below,
		i_third_phase_tied, i_fourth_phase_tied, i_arch_sel};
	// Two stages before anything reads the comparators
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= 16'h0000;
			s2_q <= 16'h0000;
		end
		else
		begin
			s1_q <= raw_in;
			s2_q <= s1_q;
		end
	end
	logic en_s, vl_ok_s, ov_mrg_s, ov_abs_s, th_hot_s, th_cool_s;
	logic trip_s, inreg_s, ph3_tied_s, ph4_tied_s;
	logic [1:0] lx_low_s, dl_low_s, arch_s;
	assign {en_s, vl_ok_s, ov_mrg_s, ov_abs_s, th_hot_s, th_cool_s, trip_s,
		inreg_s, lx_low_s, dl_low_s, ph3_tied_s, ph4_tied_s, arch_s} = s2_q;

	////////////////////////////////////////////////////////////////////////
	// Straps caught once after reset release
	logic strap_done_q;
	logic [1:0] strap_wait_q;
	logic [1:0] nph_m2_q;
	mbs_pkg::mbs_arch_t arch_q;
	// Synchroniser is cleared by the same reset; wait until it holds pins
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_done_q <= 1'h0;
			strap_wait_q <= 2'h0;
			nph_m2_q <= 2'h0;
			arch_q <= mbs_pkg::MBS_ARCH_CODE;
		end
		else if (!strap_done_q && strap_wait_q != 2'h2)
			strap_wait_q <= strap_wait_q + 2'h1;
		else if (!strap_done_q)
		begin
			strap_done_q <= 1'h1;
			if (arch_s == 2'h1)
				arch_q <= mbs_pkg::MBS_ARCH_FIX7;
			else if (arch_s == 2'h2)
				arch_q <= mbs_pkg::MBS_ARCH_FIX8;
			else
				arch_q <= mbs_pkg::MBS_ARCH_CODE;
			if (P_FOUR_PHASE == 0)
				nph_m2_q <= ph3_tied_s ? 2'h0 : 2'h1;
			else if (ph4_tied_s && ph3_tied_s)
				nph_m2_q <= 2'h0;
			else if (ph4_tied_s)
				nph_m2_q <= 2'h1;
			else
				nph_m2_q <= 2'h2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Thermal shutdown with hysteresis: trip hot, clear once cooled
	logic tshdn_q;
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			tshdn_q <= 1'h0;
		else if (th_hot_s)
			tshdn_q <= 1'h1;
		else if (th_cool_s)
			tshdn_q <= 1'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Overvoltage latch; only the core-supply reset clears it
	logic ovp_q;
	logic ov_hit;
	logic fixed_boot;
	mbs_pkg::mbs_state_t st_q;
	assign fixed_boot = (arch_q != mbs_pkg::MBS_ARCH_CODE);
	assign ov_hit = fixed_boot ? ov_mrg_s : ov_abs_s;
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ovp_q <= 1'h0;
		else if (ov_hit && st_q != mbs_pkg::MBS_ST_OFF)
			ovp_q <= 1'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Step timer: reload scales with program current
	function automatic logic [19:0] step_len(input logic [7:0] cur);
		logic [19:0] v;
		v = 20'({cur, 5'h00}) + mbs_pkg::STEP_MIN;
		return v;
	endfunction : step_len

	logic [19:0] step_cnt_q;
	logic step_tick;
	logic stepping;
	assign stepping = (st_q == mbs_pkg::MBS_ST_RAMP) ||
		(st_q == mbs_pkg::MBS_ST_STOP);
	assign step_tick = stepping && (step_cnt_q == 20'h00000);
	// Larger resistor draws less current; the ADC code is pre-inverted
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			step_cnt_q <= 20'h00000;
		else if (!stepping || step_tick)
			step_cnt_q <= step_len(i_prog_current);
		else
			step_cnt_q <= step_cnt_q - 20'h00001;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	logic [31:0] dly_q;
	logic [8:0] ref_q;
	logic [8:0] target;
	// Code-boot ramps to the live code; scaling of time comes for free
	assign target = fixed_boot ? mbs_pkg::REF_BOOT :
		{1'h0, i_voltage_code_ref};
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= mbs_pkg::MBS_ST_OFF;
			dly_q <= 32'h00000000;
			ref_q <= mbs_pkg::REF_ZERO;
		end
		else if (ovp_q)
		begin
			st_q <= mbs_pkg::MBS_ST_OVP;
			ref_q <= mbs_pkg::REF_ZERO;
		end
		else
		begin
			unique case (st_q)
				mbs_pkg::MBS_ST_OFF:
				begin
					if (en_s && strap_done_q)
					begin
						st_q <= mbs_pkg::MBS_ST_DELAY;
						dly_q <= 32'h00000000;
					end
				end
				mbs_pkg::MBS_ST_DELAY:
				begin
					if (!en_s)
						st_q <= mbs_pkg::MBS_ST_OFF;
					else if (dly_q == 32'(P_EN_DELAY_CYC - 1))
						st_q <= mbs_pkg::MBS_ST_RAMP;
					else
						dly_q <= dly_q + 32'h00000001;
				end
				mbs_pkg::MBS_ST_RAMP:
				begin
					if (!en_s)
						st_q <= mbs_pkg::MBS_ST_STOP;
					else if (ref_q >= target)
						st_q <= mbs_pkg::MBS_ST_RUN;
					else if (step_tick)
						ref_q <= ref_q + 9'h001;
				end
				mbs_pkg::MBS_ST_RUN:
				begin
					if (!en_s)
						st_q <= mbs_pkg::MBS_ST_STOP;
					else
						ref_q <= {1'h0, i_voltage_code_ref};
				end
				mbs_pkg::MBS_ST_STOP:
				begin
					if (ref_q == mbs_pkg::REF_ZERO)
						st_q <= mbs_pkg::MBS_ST_HELD;
					else if (step_tick)
						ref_q <= ref_q - 9'h001;
				end
				mbs_pkg::MBS_ST_HELD:
				begin
					if (en_s)
					begin
						st_q <= mbs_pkg::MBS_ST_DELAY;
						dly_q <= 32'h00000000;
					end
				end
				mbs_pkg::MBS_ST_OVP:
					st_q <= mbs_pkg::MBS_ST_OVP;
				default:
					st_q <= mbs_pkg::MBS_ST_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Phase drive gating
	logic switching;
	logic [3:0] act_mask;
	assign switching = !ovp_q && !tshdn_q && (st_q == mbs_pkg::MBS_ST_RAMP ||
		st_q == mbs_pkg::MBS_ST_RUN || st_q == mbs_pkg::MBS_ST_STOP);
	assign act_mask = (nph_m2_q == 2'h0) ? 4'h3 :
		(nph_m2_q == 2'h1) ? 4'h7 : 4'hF;
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			o_phase_drive <= 4'h0;
		else if (!switching)
			o_phase_drive <= 4'h0;
		else
			o_phase_drive <= i_phase_pwm & act_mask;
	end

	////////////////////////////////////////////////////////////////////////
	// Integrated gate drivers with adaptive dead time
	logic [3:0] dt_cnt_q [2];
	genvar g;
	for (g = 0; g < 2; g++)
	begin : g_drv
		always_ff @(posedge i_clk_sys or negedge rst_n)
		begin
			if (!rst_n)
			begin
				o_high_side_gate[g] <= 1'h0;
				o_low_side_gate[g] <= 1'h0;
				dt_cnt_q[g] <= 4'h0;
			end
			else if (!vl_ok_s || tshdn_q)
			begin
				o_high_side_gate[g] <= 1'h0;
				o_low_side_gate[g] <= 1'h0;
				dt_cnt_q[g] <= 4'h0;
			end
			else if (ovp_q || !switching)
			begin
				// Low-side on keeps output from rising or discharges it
				o_high_side_gate[g] <= 1'h0;
				o_low_side_gate[g] <= 1'h1;
				dt_cnt_q[g] <= mbs_pkg::DT_LOAD;
			end
			else if (i_phase_pwm[g])
			begin
				o_low_side_gate[g] <= 1'h0;
				if (!dl_low_s[g])
					dt_cnt_q[g] <= mbs_pkg::DT_LOAD;
				else if (dt_cnt_q[g] != 4'h0)
					dt_cnt_q[g] <= dt_cnt_q[g] - 4'h1;
				else if (!o_low_side_gate[g])
					o_high_side_gate[g] <= 1'h1;
			end
			else
			begin
				o_high_side_gate[g] <= 1'h0;
				dt_cnt_q[g] <= mbs_pkg::DT_LOAD;
				if (lx_low_s[g] && !o_high_side_gate[g])
					o_low_side_gate[g] <= 1'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_reference_target <= mbs_pkg::REF_ZERO;
			o_softstart_drive_2v <= 1'h0;
			o_softstart_pull_vcc <= 1'h0;
			o_power_good_out <= 1'h0;
			o_overtemp_flag_oe <= 1'h0;
			o_phase_count_m2 <= 2'h0;
		end
		else
		begin
			o_reference_target <= ref_q;
			o_softstart_drive_2v <= en_s && !ovp_q;
			o_softstart_pull_vcc <= ovp_q;
			o_power_good_out <= (st_q == mbs_pkg::MBS_ST_RUN) && inreg_s &&
				!tshdn_q;
			// Open drain: pin pulled low until past the trip point
			o_overtemp_flag_oe <= !trip_s;
			o_phase_count_m2 <= nph_m2_q;
		end
	end

endmodule : mbs_sequencer

/* File: pkg/mbs_pkg.sv */
// Constants and types for the multiphase buck sequencer.
// Assumes a single 100 MHz system clock; analog sensing arrives as
// comparator levels and a digitised program-pin current code.

package mbs_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned EN_DELAY_US = 2200;
	localparam int unsigned EN_DELAY_CYC = EN_DELAY_US * CLK_MHZ;
	localparam int unsigned DEADTIME_NS = 35;
	localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
	localparam int unsigned DEADTIME_CYC =
		(DEADTIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Reference in 6.25 mV units
	localparam int unsigned REF_W = 9;
	localparam logic [8:0] REF_BOOT = 9'h0B0;
	localparam logic [8:0] REF_OV_ABS = 9'h120;
	localparam logic [8:0] REF_OV_MARGIN = 9'h020;
	localparam logic [8:0] REF_ZERO = 9'h000;

	// Step delay: cycles per step = current code times scale, plus STEP_MIN plus one
	localparam int unsigned IPROG_W = 8;
	localparam int unsigned STEP_W = 20;
	localparam logic [19:0] STEP_SCALE = 20'h00020;
	localparam logic [19:0] STEP_MIN = 20'h00100;

	localparam int unsigned DT_W = 4;
	localparam logic [3:0] DT_LOAD = 4'(DEADTIME_CYC);

	typedef enum logic [1:0]
	{
		MBS_ARCH_CODE = 2'b00,
		MBS_ARCH_FIX7 = 2'b01,
		MBS_ARCH_FIX8 = 2'b10
	} mbs_arch_t;

	typedef enum logic [2:0]
	{
		MBS_ST_OFF = 3'b000,
		MBS_ST_DELAY = 3'b001,
		MBS_ST_RAMP = 3'b010,
		MBS_ST_RUN = 3'b011,
		MBS_ST_STOP = 3'b100,
		MBS_ST_HELD = 3'b101,
		MBS_ST_OVP = 3'b110
	} mbs_state_t;

endpackage : mbs_pkg

/* File: verif/mbs_power_stage.sv */
// Power-stage model: gate commands in, comparator levels out.
// Assumes gate and switch node settle within one or two clocks.
`timescale 1ns/10ps

module mbs_power_stage (
	input wire logic i_clk_sys,
	input wire logic i_slow,
	input wire logic [1:0] i_high_side_gate,
	input wire logic [1:0] i_low_side_gate,
	output logic [1:0] o_switch_node_low = 2'h3,
	output logic [1:0] o_low_gate_below = 2'h3
);
	logic [1:0] sw_q = 2'h3;
	logic [1:0] lg_q = 2'h3;

	// Slow mode models heavy gate charge: one extra clock of lag
	always @(posedge i_clk_sys)
	begin
		sw_q <= ~i_high_side_gate;
		lg_q <= ~i_low_side_gate;
		o_switch_node_low <= i_slow ? sw_q : ~i_high_side_gate;
		o_low_gate_below <= i_slow ? lg_q : ~i_low_side_gate;
	end
endmodule : mbs_power_stage

/* File: verif/mbs_sequencer_properties.sv */
// Port-level checker for the multiphase buck sequencer.
// Assumes it is bound to mbs_sequencer; one clock domain.
`timescale 1ns/10ps

module mbs_seq_chk (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_enable,
	input wire logic i_driver_supply_ok,
	input wire logic i_thermal_hot,
	input wire logic i_temp_over_trip,
	input wire logic [3:0] o_phase_drive,
	input wire logic [1:0] o_phase_count_m2,
	input wire logic [1:0] o_high_side_gate,
	input wire logic [1:0] o_low_side_gate,
	input wire logic [8:0] o_reference_target,
	input wire logic o_softstart_pull_vcc,
	input wire logic o_power_good_out,
	input wire logic o_overtemp_flag_oe
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	////////////////////////////////////////////////////////////////////////
	a_inactive_phase_low: assert property (
		(o_phase_count_m2 != 2'h2 |-> !o_phase_drive[3]) and
		(o_phase_count_m2 == 2'h0 |-> !o_phase_drive[2]))
		else $error("drive on an inactive phase");
	a_pg_off_disabled: assert property (
		!i_enable [*5] |-> !o_power_good_out)
		else $error("power good while disabled");
	a_drv_uv_low: assert property (
		!i_driver_supply_ok [*4] |->
		o_high_side_gate == 2'h0 && o_low_side_gate == 2'h0)
		else $error("gates on in driver undervoltage");
	a_ovp_sticky: assert property (
		o_softstart_pull_vcc |=> o_softstart_pull_vcc)
		else $error("overvoltage latch released");
	a_ovp_gates_off: assert property (
		o_softstart_pull_vcc [*2] |->
		o_phase_drive == 4'h0 && o_high_side_gate == 2'h0)
		else $error("switching during overvoltage");
	a_ref_step_up: assert property (
		o_reference_target > $past(o_reference_target) |->
		o_reference_target == $past(o_reference_target) + 9'h001)
		else $error("reference rose by more than one step");
	a_step_gap: assert property (
		o_reference_target > $past(o_reference_target) |=>
		$stable(o_reference_target) [*8])
		else $error("reference steps too close");
	// Four cycles cover 35 ns at 10 ns per cycle
	a_dead_time: assert property (
		$rose(o_high_side_gate[0]) |-> !o_low_side_gate[0] &&
		!$past(o_low_side_gate[0]) && !$past(o_low_side_gate[0], 2) &&
		!$past(o_low_side_gate[0], 3))
		else $error("high side on too soon");
	a_no_shoot: assert property (
		(o_high_side_gate & o_low_side_gate) == 2'h0)
		else $error("both gates of a phase on");
	a_hot_all_off: assert property (
		i_thermal_hot [*5] |-> o_phase_drive == 4'h0 &&
		o_high_side_gate == 2'h0 && o_low_side_gate == 2'h0)
		else $error("switching while hot");
	a_flag_follows: assert property (
		i_temp_over_trip [*4] |-> !o_overtemp_flag_oe)
		else $error("overtemp flag missing");
endmodule : mbs_seq_chk

bind mbs_sequencer mbs_seq_chk mbs_seq_chk_i (
	.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_enable(i_enable),
	.i_driver_supply_ok(i_driver_supply_ok),
	.i_thermal_hot(i_thermal_hot), .i_temp_over_trip(i_temp_over_trip),
	.o_phase_drive(o_phase_drive), .o_phase_count_m2(o_phase_count_m2),
	.o_high_side_gate(o_high_side_gate),
	.o_low_side_gate(o_low_side_gate),
	.o_reference_target(o_reference_target),
	.o_softstart_pull_vcc(o_softstart_pull_vcc),
	.o_power_good_out(o_power_good_out),
	.o_overtemp_flag_oe(o_overtemp_flag_oe));

/* File: verif/tb_mbs_sequencer.sv */
// Self-checking bench for the multiphase buck sequencer.
// Assumes the power-stage model on the gate side, short enable delay.
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
$display("Error %0t: got %0h want %0h", $time, (a), (e)); end end
`define WAITU(c, n) begin int k; k = 0; \
do begin tick(1); k++; end while (!(c) && k < (n)); end

module tb_mbs_sequencer;
	localparam int DLY = 50;
	localparam int STEP = 257;
	logic i_clk_sys = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_enable = 1'b0;
	logic i_driver_supply_ok = 1'b1;
	logic i_third_phase_tied = 1'b0;
	logic i_fourth_phase_tied = 1'b1;
	logic [1:0] i_arch_sel = 2'h0;
	logic [7:0] i_voltage_code_ref = 8'h04;
	logic [7:0] i_prog_current = 8'h00;
	logic i_out_above_margin = 1'b0;
	logic i_out_above_abs = 1'b0;
	logic i_thermal_hot = 1'b0;
	logic i_thermal_cool = 1'b0;
	logic i_temp_over_trip = 1'b0;
	logic i_in_regulation = 1'b1;
	logic [3:0] i_phase_pwm = 4'h0;
	logic i_slow = 1'b0;
	logic [1:0] sw_low, lg_below, hs, ls, cnt;
	logic [1:0] cnt3;
	logic [3:0] drv;
	logic [8:0] ref_t;
	logic ss2v, ovp, pg, hot_oe;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;

	mbs_sequencer #(.P_FOUR_PHASE(1), .P_EN_DELAY_CYC(DLY)) mbs_sequencer_i (
		.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_enable(i_enable),
		.i_driver_supply_ok(i_driver_supply_ok),
		.i_third_phase_tied(i_third_phase_tied),
		.i_fourth_phase_tied(i_fourth_phase_tied), .i_arch_sel(i_arch_sel),
		.i_voltage_code_ref(i_voltage_code_ref),
		.i_prog_current(i_prog_current),
		.i_out_above_margin(i_out_above_margin),
		.i_out_above_abs(i_out_above_abs), .i_thermal_hot(i_thermal_hot),
		.i_thermal_cool(i_thermal_cool), .i_temp_over_trip(i_temp_over_trip),
		.i_in_regulation(i_in_regulation), .i_phase_pwm(i_phase_pwm),
		.i_switch_node_low(sw_low), .i_low_gate_below(lg_below),
		.o_phase_drive(drv), .o_phase_count_m2(cnt),
		.o_high_side_gate(hs), .o_low_side_gate(ls),
		.o_reference_target(ref_t), .o_softstart_drive_2v(ss2v),
		.o_softstart_pull_vcc(ovp), .o_power_good_out(pg),
		.o_overtemp_flag_oe(hot_oe));
	mbs_power_stage mbs_power_stage_i (.i_clk_sys(i_clk_sys),
		.i_slow(i_slow), .i_high_side_gate(hs), .i_low_side_gate(ls),
		.o_switch_node_low(sw_low), .o_low_gate_below(lg_below));
	// Three-phase variant shares all stimulus; the bench judges only its count
	mbs_sequencer #(.P_FOUR_PHASE(0), .P_EN_DELAY_CYC(DLY))
		mbs_sequencer_three_i (
		.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_enable(i_enable),
		.i_driver_supply_ok(i_driver_supply_ok),
		.i_third_phase_tied(i_third_phase_tied),
		.i_fourth_phase_tied(i_fourth_phase_tied), .i_arch_sel(i_arch_sel),
		.i_voltage_code_ref(i_voltage_code_ref),
		.i_prog_current(i_prog_current),
		.i_out_above_margin(i_out_above_margin),
		.i_out_above_abs(i_out_above_abs), .i_thermal_hot(i_thermal_hot),
		.i_thermal_cool(i_thermal_cool), .i_temp_over_trip(i_temp_over_trip),
		.i_in_regulation(i_in_regulation), .i_phase_pwm(i_phase_pwm),
		.i_switch_node_low(sw_low), .i_low_gate_below(lg_below),
		.o_phase_drive(), .o_phase_count_m2(cnt3),
		.o_high_side_gate(), .o_low_side_gate(),
		.o_reference_target(), .o_softstart_drive_2v(),
		.o_softstart_pull_vcc(), .o_power_good_out(),
		.o_overtemp_flag_oe());

	////////////////////////////////////////////////////////////////////////
	always #5 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys)
	begin
		i_phase_pwm <= {4{cyc[4]}};
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			err_total++;
			report_and_stop;
		end
	end

	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	// Settle past the edge so registered outputs are read after update
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : tick

	task automatic do_reset(input logic [1:0] a, input logic t3, t4);
		@(posedge i_clk_sys);
		i_arst_n <= 1'b0;
		i_enable <= 1'b0;
		i_arch_sel <= a;
		i_third_phase_tied <= t3;
		i_fourth_phase_tied <= t4;
		tick(20);
		`CHK(ovp, 1'b0)
		@(posedge i_clk_sys);
		i_arst_n <= 1'b1;
		tick(8);
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////
	task automatic t_straps;
		for (int i = 0; i < 3; i++)
		begin
			do_reset(2'h0, i == 0, i < 2);
			`CHK(cnt, 2'(i))
			`CHK(cnt3, (i == 0) ? 2'h0 : 2'h1)
		end
		`CHK(ls, 2'h3)
		`CHK(hs, 2'h0)
		@(posedge i_clk_sys);
		i_driver_supply_ok <= 1'b0;
		tick(6);
		`CHK({hs, ls}, 4'h0)
		@(posedge i_clk_sys);
		i_driver_supply_ok <= 1'b1;
		$display("straps and idle gates done");
	endtask : t_straps

	task automatic start(input logic [1:0] a, input logic [7:0] code);
		do_reset(a, 1'b0, 1'b1);
		@(posedge i_clk_sys);
		i_voltage_code_ref <= code;
		i_prog_current <= 8'h00;
		i_enable <= 1'b1;
		tick(DLY);
		`CHK(ref_t, 9'h000)
		`CHK(ss2v, 1'b1)
	endtask : start

	task automatic t_run;
		start(2'h0, 8'h04);
		`WAITU(ref_t == 9'h004, 5 * STEP)
		`CHK(ref_t, 9'h004)
		`CHK(pg, 1'b0)
		tick(5);
		`CHK(pg, 1'b1)
		`WAITU(drv[0], 64)
		`CHK(drv, 4'h7)
		`WAITU(hs[0], 64)
		`CHK(hs[0], 1'b1)
		@(posedge i_clk_sys);
		i_thermal_hot <= 1'b1;
		i_temp_over_trip <= 1'b1;
		tick(6);
		`CHK({drv, hs, ls}, 8'h00)
		`CHK(hot_oe, 1'b0)
		@(posedge i_clk_sys);
		i_thermal_hot <= 1'b0;
		i_temp_over_trip <= 1'b0;
		tick(6);
		`CHK({drv, hs, ls}, 8'h00)
		`CHK(hot_oe, 1'b1)
		@(posedge i_clk_sys);
		i_thermal_cool <= 1'b1;
		`WAITU(|{hs, ls}, 80)
		`CHK(|{hs, ls}, 1'b1)
		@(posedge i_clk_sys);
		i_thermal_cool <= 1'b0;
		i_enable <= 1'b0;
		`WAITU(ref_t == 9'h000, 5 * STEP)
		tick(5);
		`CHK({ref_t, ls, hs, drv, pg}, {9'h000, 2'h3, 6'h00, 1'b0})
		$display("run, thermal and stop done");
	endtask : t_run

	task automatic t_ovp;
		@(posedge i_clk_sys);
		i_slow <= 1'b1;
		start(2'h0, 8'h04);
		`WAITU(pg, 5 * STEP)
		@(posedge i_clk_sys);
		i_out_above_abs <= 1'b1;
		tick(6);
		`CHK({ovp, drv, hs, ls}, {1'b1, 6'h00, 2'h3})
		@(posedge i_clk_sys);
		i_out_above_abs <= 1'b0;
		i_enable <= 1'b0;
		tick(10);
		@(posedge i_clk_sys);
		i_enable <= 1'b1;
		tick(DLY + 20);
		`CHK({ovp, drv}, 5'h10)
		$display("overvoltage latch done");
	endtask : t_ovp

	// Code 0x10 would stop a code-boot ramp; fixed boot must pass it
	task automatic t_fixboot;
		for (int a = 1; a < 3; a++)
		begin
			start(2'(a), 8'h10);
			`WAITU(ref_t == 9'h011, 20 * STEP)
			`CHK(ref_t, 9'h011)
			if (a == 2)
			begin
				@(posedge i_clk_sys);
				i_voltage_code_ref <= 8'(mbs_pkg::REF_BOOT);
				`WAITU(ref_t == mbs_pkg::REF_BOOT, 180 * STEP)
				`CHK(ref_t, mbs_pkg::REF_BOOT)
				tick(10);
				`CHK(ref_t, mbs_pkg::REF_BOOT)
			end
			@(posedge i_clk_sys);
			i_out_above_margin <= 1'b1;
			tick(6);
			`CHK(ovp, 1'b1)
			@(posedge i_clk_sys);
			i_out_above_margin <= 1'b0;
		end
		$display("fixed boot done");
	endtask : t_fixboot

	initial
	begin
		t_straps;
		t_run;
		t_ovp;
		t_fixboot;
		report_and_stop;
	end
endmodule : tb_mbs_sequencer
